/* File: logic/srap_port.sv */
// serial register access port with trim register store
`timescale 1ns/10ps
module srap_port #(
   parameter int NUM_INPUTS = srap_pkg::SRAP_NINPUT
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic select_n,
   input wire logic sclk,
   input wire logic ser_in,
   output logic ser_out,
   output logic ser_out_oe,
   input wire logic offset_cal_on,
   input wire logic background_cal_on,
   input wire srap_pkg::srap_cal_s cal,
   output srap_pkg::srap_trim_s trims,
   output logic addr_dir_up,
   output logic addr_hold
);
   import srap_pkg::*;

   typedef struct packed {
      srap_state_e st;
      logic [4:0] cnt;
      logic [15:0] sh;
      logic rw;
      logic [14:0] addr;
      logic [7:0] tx;
      logic fresh;
      logic sck_prev;
      logic so;
      logic oe;
      logic [SRAP_NINPUT-1:0][7:0] term;
      logic [SRAP_NBYTE-1:0][7:0] regs;
   } srap_core_s;

   srap_core_s q;
   srap_core_s d;
   srap_pins_s pins;
   srap_pins_s pins_s;

   logic cs_s;
   logic sck_s;
   logic sdi_s;
   logic sck_rise;
   logic sck_fall;
   logic byte_done;
   logic wr_fire;
   logic cal_fire;
   logic [7:0] byte_in;

   // map an address to a byte of the store, msb flags a hit
   function automatic logic [5:0] map_idx(input logic [14:0] a);
      logic [14:0] o;
      logic [5:0] r;
      r = '0;
      if (a == SRAP_CFG_ADDR) begin
         r = {1'b1, SRAP_IX_CFG};
      end
      if (a == SRAP_REF_ADDR) begin
         r = {1'b1, SRAP_IX_REF};
      end
      o = a - SRAP_FS_ADDR;
      if (o < SRAP_FS_N) begin
         r = {1'b1, SRAP_IX_FS + o[4:0]};
      end
      o = a - SRAP_TERM_ADDR;
      if (o < SRAP_TERM_N) begin
         r = {1'b1, SRAP_IX_TERM + o[4:0]};
      end
      o = a - SRAP_OFS_ADDR;
      if (o < SRAP_OFS_N) begin
         r = {1'b1, SRAP_IX_OFS + o[4:0]};
      end
      o = a - SRAP_GAIN_ADDR;
      if (o < SRAP_GAIN_N) begin
         r = {1'b1, SRAP_IX_GAIN + o[4:0]};
      end
      return r;
   endfunction

   function automatic logic [7:0] rd_byte(
      input logic [14:0] a,
      input logic [SRAP_NBYTE-1:0][7:0] m
   );
      logic [5:0] r;
      r = map_idx(a);
      return r[5] ? m[r[4:0]] : SRAP_UNMAPPED_RD;
   endfunction

   assign pins.select_n = select_n;
   assign pins.sclk = sclk;
   assign pins.ser_in = ser_in;

   srap_sync #(
      .W(3),
      .RST(SRAP_PIN_RST)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .din(pins),
      .dout(pins_s)
   );

   assign cs_s = pins_s.select_n;
   assign sck_s = pins_s.sclk;
   assign sdi_s = pins_s.ser_in;
   assign sck_rise = sck_s & ~q.sck_prev;
   assign sck_fall = ~sck_s & q.sck_prev;
   assign byte_done = (q.st == st_val) & ~cs_s & sck_rise &
      (q.cnt == 5'(SRAP_VAL_BITS - 1));
   assign wr_fire = byte_done & ~q.rw;
   assign byte_in = {q.sh[6:0], sdi_s};
   assign cal_fire = cal.wr & offset_cal_on & background_cal_on &
      (int'(cal.core) < SRAP_NCORE);

   always_comb begin
      logic [5:0] wi;
      logic [14:0] nxt;
      logic [14:0] hdr_addr;
      logic [4:0] ci;
      wi = map_idx(q.addr);
      nxt = q.addr;
      hdr_addr = {q.sh[13:0], sdi_s};
      ci = SRAP_IX_OFS + {1'b0, cal.core, 1'b0};
      d = q;
      d.sck_prev = sck_s;
      case (q.st)
         st_idle: begin
            // no time limit anywhere: framing waits on edges only
            if (!cs_s) begin
               d.st = st_cmd;
               d.cnt = '0;
            end
         end
         st_cmd: begin
            if (cs_s) begin
               d.st = st_idle;
            end else if (sck_rise) begin
               d.sh = {q.sh[14:0], sdi_s};
               d.cnt = q.cnt + 5'h01;
               if (q.cnt == 5'(SRAP_HDR_BITS - 1)) begin
                  d.rw = q.sh[14];
                  d.addr = hdr_addr;
                  d.tx = rd_byte(hdr_addr, q.regs);
                  d.fresh = 1'b1;
                  d.cnt = '0;
                  d.st = st_val;
               end
            end
         end
         st_val: begin
            if (cs_s) begin
               d.st = st_idle;
            end else begin
               if (sck_fall) begin
                  // the first fall after a load keeps the msb out
                  if (q.fresh) begin
                     d.fresh = 1'b0;
                  end else begin
                     d.tx = {q.tx[6:0], 1'b0};
                  end
               end
               if (sck_rise) begin
                  d.sh = {q.sh[14:0], sdi_s};
                  d.cnt = q.cnt + 5'h01;
                  if (byte_done) begin
                     if (!q.rw && wi[5]) begin
                        d.regs[wi[4:0]] = byte_in;
                     end
                     if (!q.regs[SRAP_IX_CFG][SRAP_CFG_HOLD_BIT]) begin
                        if (q.regs[SRAP_IX_CFG][SRAP_CFG_UP_BIT]) begin
                           nxt = q.addr + 15'h0001;
                        end else begin
                           nxt = q.addr - 15'h0001;
                        end
                     end
                     d.addr = nxt;
                     d.tx = rd_byte(nxt, d.regs);
                     d.fresh = 1'b1;
                     d.cnt = '0;
                  end
               end
            end
         end
         default: begin
            d.st = st_idle;
         end
      endcase
      // calibration results land after host writes, so they win
      if (cal_fire) begin
         d.regs[ci] = cal.value[7:0];
         d.regs[ci + 5'h01] = cal.value[15:8];
      end
      for (int i = 0; i < SRAP_NINPUT; i++) begin
         if (i < NUM_INPUTS) begin
            d.term[i] = d.regs[SRAP_IX_TERM + 5'(i)];
         end else begin
            d.term[i] = 8'h00;
         end
      end
      d.oe = (d.st == st_val) & d.rw;
      d.so = d.tx[7];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         // sclk idles low, so the edge detector starts low too
         q <= '0;
         q.regs <= SRAP_REG_RST;
      end else begin
         q <= d;
      end
   end

   assign ser_out = q.so;
   assign ser_out_oe = q.oe;
   assign addr_dir_up = q.regs[SRAP_IX_CFG][SRAP_CFG_UP_BIT];
   assign addr_hold = q.regs[SRAP_IX_CFG][SRAP_CFG_HOLD_BIT];
   // one range for every input, per-core gain trims do the matching
   assign trims.full_scale_setting = {
      q.regs[SRAP_IX_FS + 5'h01], q.regs[SRAP_IX_FS]};
   assign trims.reference_trim = q.regs[SRAP_IX_REF];
   assign trims.termination_trim = q.term;

   for (genvar c = 0; c < SRAP_NCORE; c++) begin : g_core
      assign trims.core_offset_trim[c] = {
         q.regs[SRAP_IX_OFS + 5'(2 * c + 1)],
         q.regs[SRAP_IX_OFS + 5'(2 * c)]};
      assign trims.core_gain_trim[c] = q.regs[SRAP_IX_GAIN + 5'(c)];
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_drive_read_val: assert property (
      q.oe |-> (q.st == st_val) && q.rw
   ) else $error("ser_out driven outside a read value phase");

   a_select_high_idle: assert property (
      cs_s |=> q.st == st_idle && !q.oe
   ) else $error("port active while select is high");

   a_sample_rising: assert property (
      (q.st == st_cmd) && !cs_s && sck_rise |=> q.sh[0] == $past(sdi_s)
   ) else $error("input bit not taken on rising sclk");

   a_header_length: assert property (
      (q.st == st_cmd) && !cs_s && sck_rise && q.cnt == 5'h0f
      |=> q.st == st_val && q.cnt == 5'h00
   ) else $error("header did not end after sixteen bits");

   a_direction_bit: assert property (
      (q.st == st_cmd) && !cs_s && sck_rise && q.cnt == 5'h0f
      |=> q.rw == $past(q.sh[14]) && q.oe == $past(q.sh[14])
   ) else $error("direction bit misread");

   a_write_stores: assert property (
      wr_fire && q.addr == SRAP_REF_ADDR
      |=> trims.reference_trim == $past(byte_in)
   ) else $error("written value not stored");

   a_read_keeps: assert property (
      byte_done && q.rw && !cal_fire |=> $stable(q.regs)
   ) else $error("read frame changed a register");

   a_step_up: assert property (
      byte_done && !addr_hold && addr_dir_up
      |=> q.addr == $past(q.addr) + 15'h0001
   ) else $error("streaming address did not increment");

   a_step_down: assert property (
      byte_done && !addr_hold && !addr_dir_up
      |=> q.addr == $past(q.addr) - 15'h0001
   ) else $error("streaming address did not decrement");

   a_hold_addr: assert property (
      byte_done && addr_hold |=> $stable(q.addr)
   ) else $error("held address moved");

   a_offset_deposit: assert property (
      cal_fire |=> trims.core_offset_trim[$past(cal.core)] ==
         $past(cal.value)
   ) else $error("calibration offset not deposited");

   a_gain_static: assert property (
      !wr_fire |=> $stable(trims.core_gain_trim)
   ) else $error("gain trim changed without a host write");

   a_abort_clean: assert property (
      (q.st != st_idle) && cs_s && !cal_fire
      |=> $stable(q.regs) ##1 q.st == st_idle
   ) else $error("aborted frame changed a register");

   a_addr_taken: assert property (
      (q.st == st_cmd) && !cs_s && sck_rise && q.cnt == 5'h0f
      |=> q.addr == {$past(q.sh[13:0]), $past(sdi_s)}
   ) else $error("header address misread");

   a_read_loads: assert property (
      (q.st == st_cmd) && !cs_s && sck_rise && q.cnt == 5'h0f && q.sh[14]
      |=> q.oe && q.so == q.tx[7] && q.fresh
   ) else $error("read value not presented after the header");

   a_msb_out_first: assert property (
      q.oe && sck_fall && !q.fresh && !cs_s |=> q.so == $past(q.tx[6])
   ) else $error("read data not shifted msb first");

   a_write_quiet: assert property (
      (q.st == st_val) && !q.rw |-> !q.oe
   ) else $error("ser_out driven during a write frame");

   a_stream_next: assert property (
      byte_done |=> q.st == st_val && q.cnt == 5'h00
   ) else $error("streaming did not continue after a byte");

   a_static_wait: assert property (
      (q.st != st_idle) && !cs_s && !sck_rise
      |=> q.cnt == $past(q.cnt) && q.st == $past(q.st)
   ) else $error("frame advanced without a serial clock edge");

   a_idle_ignores: assert property (
      (q.st == st_idle) && cs_s |=> $stable(q.sh) && $stable(q.cnt)
   ) else $error("deselected port took serial input");

   a_cal_gated: assert property (
      !cal_fire && !wr_fire |=> $stable(trims.core_offset_trim)
   ) else $error("offset trim changed without a deposit or write");

   for (genvar i = 0; i < SRAP_NINPUT; i++) begin : g_unused
      if (i >= NUM_INPUTS) begin : g_chk
         a_term_unused: assert property (
            trims.termination_trim[i] == 8'h00
         ) else $error("absent input trim has an effect");
      end
   end

   c_read_frame: cover property (byte_done && q.rw);
   c_stream_write: cover property (wr_fire ##[1:200] wr_fire);
   c_abort_value: cover property ((q.st == st_val) && cs_s);
   c_cal_deposit: cover property (cal_fire);
   c_stream_read: cover property (
      byte_done && q.rw ##[1:200] byte_done && q.rw);
endmodule

/* File: logic/srap_pkg.sv */
// package: constants and types of the serial register access port
package srap_pkg;
   localparam int SRAP_HDR_BITS = 16;
   localparam int SRAP_VAL_BITS = 8;
   localparam int SRAP_NCORE = 6;
   localparam int SRAP_NINPUT = 4;
   localparam int SRAP_NBYTE = 26;
   // register addresses
   localparam logic [14:0] SRAP_CFG_ADDR = 15'h0010;
   localparam logic [14:0] SRAP_FS_ADDR = 15'h0030;
   localparam logic [14:0] SRAP_REF_ADDR = 15'h007c;
   localparam logic [14:0] SRAP_TERM_ADDR = 15'h007e;
   localparam logic [14:0] SRAP_OFS_ADDR = 15'h0330;
   localparam logic [14:0] SRAP_GAIN_ADDR = 15'h0350;
   // bytes in each register group
   localparam logic [14:0] SRAP_FS_N = 15'h0002;
   localparam logic [14:0] SRAP_TERM_N = 15'h0004;
   localparam logic [14:0] SRAP_OFS_N = 15'h000c;
   localparam logic [14:0] SRAP_GAIN_N = 15'h0006;
   // positions in the byte store
   localparam logic [4:0] SRAP_IX_CFG = 5'h00;
   localparam logic [4:0] SRAP_IX_FS = 5'h01;
   localparam logic [4:0] SRAP_IX_REF = 5'h03;
   localparam logic [4:0] SRAP_IX_TERM = 5'h04;
   localparam logic [4:0] SRAP_IX_OFS = 5'h08;
   localparam logic [4:0] SRAP_IX_GAIN = 5'h14;
   localparam int SRAP_CFG_HOLD_BIT = 0;
   localparam int SRAP_CFG_UP_BIT = 1;
   localparam logic [7:0] SRAP_CFG_RST = 8'h02;
   localparam logic [15:0] SRAP_FS_RST = 16'ha000;
   localparam logic [7:0] SRAP_UNMAPPED_RD = 8'h00;
   localparam logic [SRAP_NBYTE-1:0][7:0] SRAP_REG_RST =
      {184'h0, SRAP_FS_RST, SRAP_CFG_RST};
   localparam logic [2:0] SRAP_PIN_RST = 3'h5;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_cmd = 2'b01,
      st_val = 2'b11
   } srap_state_e;

   typedef struct packed {
      logic select_n;
      logic sclk;
      logic ser_in;
   } srap_pins_s;

   typedef struct packed {
      logic wr;
      logic [2:0] core;
      logic [15:0] value;
   } srap_cal_s;

   typedef struct packed {
      logic [15:0] full_scale_setting;
      logic [7:0] reference_trim;
      logic [SRAP_NINPUT-1:0][7:0] termination_trim;
      logic [SRAP_NCORE-1:0][15:0] core_offset_trim;
      logic [SRAP_NCORE-1:0][7:0] core_gain_trim;
   } srap_trim_s;
endpackage

/* File: logic/srap_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module srap_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] f;
   } srap_sync_s;

   srap_sync_s q;
   srap_sync_s d;

   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // a bit changes only once stages two and three agree
      d.f = (q.s2 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= {RST, RST, RST, RST};
      end else begin
         q <= d;
      end
   end

   assign dout = q.f;
endmodule

/* File: tb/srap_host.sv */
// host side model: frames select_n, clocks sclk and ser_in, samples ser_out
`timescale 1ns/10ps
module srap_host (
   input wire logic clk,
   output logic select_n,
   output logic sclk,
   output logic ser_in,
   input wire logic ser_out,
   input wire logic ser_out_oe
);
   int half = 4;
   int oe_bad = 0;
   logic last_q = 1'b0;
   logic line;
   // released output shows the inverse of its last driven level
   assign line = ser_out_oe ? ser_out : ~last_q;
   always @(posedge clk) begin
      if (ser_out_oe) begin
         last_q <= ser_out;
      end
   end
   initial begin
      select_n = 1'b1;
      sclk = 1'b0;
      ser_in = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic start();
      @(negedge clk);
      select_n = 1'b0;
      wait_clk(half);
   endtask
   task automatic stop();
      sclk = 1'b0;
      wait_clk(half);
      select_n = 1'b1;
      ser_in = ~ser_in;
      wait_clk(8);
   endtask
   // nb bits msb first; ser_out must be driven exactly when exp_oe is set
   task automatic shift(input logic [7:0] tx, input logic exp_oe,
                        input int nb, output logic [7:0] rx);
      rx = '0;
      for (int i = 7; i > 7 - nb; i--) begin
         sclk = 1'b0;
         ser_in = tx[i];
         wait_clk(half);
         sclk = 1'b1;
         wait_clk(half);
         // output follows a fall only after the pin sync: take it late
         rx[i] = line;
         if (ser_out_oe !== exp_oe) oe_bad++;
      end
   endtask
endmodule

/* File: tb/tb_serial_register_access_port.sv */
// self-checking bench of the serial register access port
`timescale 1ns/10ps
module tb_serial_register_access_port;
   import srap_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic select_n, sclk, ser_in, ser_out, ser_out_oe;
   logic offset_cal_on = 1'b0;
   logic background_cal_on = 1'b0;
   srap_cal_s cal = '0;
   srap_trim_s trims;
   logic addr_dir_up, addr_hold;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] rx;
   logic [7:0] got[$];
   always #5 clk = ~clk;
   srap_port #(.NUM_INPUTS(2)) dut (.clk(clk), .reset(reset),
      .select_n(select_n), .sclk(sclk), .ser_in(ser_in), .ser_out(ser_out),
      .ser_out_oe(ser_out_oe), .offset_cal_on(offset_cal_on),
      .background_cal_on(background_cal_on), .cal(cal), .trims(trims),
      .addr_dir_up(addr_dir_up), .addr_hold(addr_hold));
   srap_host host (.clk(clk), .select_n(select_n), .sclk(sclk),
      .ser_in(ser_in), .ser_out(ser_out), .ser_out_oe(ser_out_oe));
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // header then the given bytes; bytes read back land in got
   task automatic frame(input logic rd, input logic [14:0] a,
                        input logic [7:0] d[$]);
      logic [7:0] r;
      got.delete();
      host.start();
      host.shift({rd, a[14:8]}, 1'b0, 8, r);
      host.shift(a[7:0], 1'b0, 8, r);
      foreach (d[i]) begin
         host.shift(d[i], rd, 8, r);
         got.push_back(r);
      end
      host.stop();
   endtask
   // input bits of a read carry the inverse of the expected bytes
   task automatic rd_chk(input string what, input logic [14:0] a,
                         input logic [7:0] e[$]);
      logic [7:0] d[$];
      foreach (e[i]) d.push_back(~e[i]);
      frame(1'b1, a, d);
      foreach (e[i]) check(what, 16'(got[i]), 16'(e[i]));
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      check("oe", 16'(ser_out_oe), 16'h0);
      check("fs", trims.full_scale_setting, SRAP_FS_RST);
      check("dir", 16'(addr_dir_up), 16'h1);
      check("hold", 16'(addr_hold), 16'h0);
      // clocking while deselected must not start a frame
      host.shift(8'h80, 1'b0, 8, rx);
      frame(1'b0, SRAP_REF_ADDR, '{8'h35});
      check("ref", 16'(trims.reference_trim), 16'h35);
      rd_chk("ref rd", SRAP_REF_ADDR, '{8'h35});
      host.start();
      host.shift({1'b0, SRAP_REF_ADDR[14:8]}, 1'b0, 8, rx);
      host.shift(SRAP_REF_ADDR[7:0], 1'b0, 8, rx);
      host.shift(8'hc3, 1'b0, 5, rx);
      host.stop();
      check("abort", 16'(trims.reference_trim), 16'h35);
      frame(1'b0, SRAP_REF_ADDR, '{8'h5a});
      check("after", 16'(trims.reference_trim), 16'h5a);
      frame(1'b0, SRAP_OFS_ADDR, '{8'h11, 8'h22, 8'h33, 8'h44});
      check("ofs0", trims.core_offset_trim[0], 16'h2211);
      check("ofs1", trims.core_offset_trim[1], 16'h4433);
      rd_chk("ofs rd", SRAP_OFS_ADDR, '{8'h11, 8'h22, 8'h33});
      rd_chk("unmapped", 15'h7000, '{SRAP_UNMAPPED_RD});
      frame(1'b0, SRAP_CFG_ADDR, '{8'h00});
      check("dir dn", 16'(addr_dir_up), 16'h0);
      frame(1'b0, SRAP_GAIN_ADDR + 15'h2, '{8'ha1, 8'ha2, 8'ha3});
      check("g2", 16'(trims.core_gain_trim[2]), 16'ha1);
      check("g1", 16'(trims.core_gain_trim[1]), 16'ha2);
      check("g0", 16'(trims.core_gain_trim[0]), 16'ha3);
      frame(1'b0, SRAP_CFG_ADDR, '{8'h01});
      check("hold on", 16'(addr_hold), 16'h1);
      frame(1'b0, SRAP_GAIN_ADDR + 15'h5, '{8'h77, 8'h88});
      check("g5", 16'(trims.core_gain_trim[5]), 16'h88);
      check("g4", 16'(trims.core_gain_trim[4]), 16'h00);
      rd_chk("hold rd", SRAP_GAIN_ADDR + 15'h5, '{8'h88, 8'h88});
      frame(1'b0, SRAP_CFG_ADDR, '{8'h02});
      check("oe bad", 16'(host.oe_bad), 16'h0);
      host.half = 25;
      frame(1'b0, SRAP_FS_ADDR, '{8'h34, 8'h12});
      check("fs wr", trims.full_scale_setting, 16'h1234);
      host.half = 4;
      frame(1'b0, SRAP_TERM_ADDR, '{8'h12, 8'h00, 8'h00, 8'h9a});
      check("t0", 16'(trims.termination_trim[0]), 16'h12);
      check("t3", 16'(trims.termination_trim[3]), 16'h00);
      rd_chk("t3 rd", SRAP_TERM_ADDR + 15'h3, '{8'h9a});
      // deposits land only while both cal enables are on and the core is below SRAP_NCORE
      offset_cal_on = 1'b1;
      background_cal_on = 1'b1;
      cal = '{wr: 1'b1, core: 3'h3, value: 16'hbeef};
      @(negedge clk);
      cal.core = 3'h6;
      @(negedge clk);
      background_cal_on = 1'b0;
      cal.core = 3'h1;
      @(negedge clk);
      cal.wr = 1'b0;
      offset_cal_on = 1'b0;
      @(negedge clk);
      check("ofs3", trims.core_offset_trim[3], 16'hbeef);
      check("ofs1 kept", trims.core_offset_trim[1], 16'h4433);
      check("ofs0 kept", trims.core_offset_trim[0], 16'h2211);
      check("gain", 16'(trims.core_gain_trim[2]), 16'ha1);
      conclude();
   end
endmodule
